// file: core/cmpev_pkg.sv
// Constants, register map and field layout of the comparator event logic.
// Assumes a classic Wishbone slave port with 32-bit data and byte addresses.
//
// Summary of operation
// - Status bits 7:6 show comparator results, read-only
// - Pin drive bit routes result to pin
// - Port direction bits still enable pin drivers
// - Invert bit flips the reported comparator result
// - Select 01 rising, 10 falling sets flag
// - Select 11 sets flag on any change
// - Select 00 never sets the flag
// - Edges detected after the polarity inversion
// - Flag holds until software writes zero
// - Software writing one sets flag, simulates event
// - Flags and enables at bits 5:4
// - Interrupt needs all three enables; flag regardless
// - Enabled comparator events wake device from sleep
// - Sleep wake leaves control registers unchanged
// - Reset loads control registers, comparators off
// - Control bit 7 switches the comparator on
// - Selecting any-change mode sets flag at once

package cmpev_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] CMPEV_OFS_CTL1   = 8'h00;
    localparam logic [7:0] CMPEV_OFS_CTL2   = 8'h04;
    localparam logic [7:0] CMPEV_OFS_STATUS = 8'h08;
    localparam logic [7:0] CMPEV_OFS_FLAGS  = 8'h0c;
    localparam logic [7:0] CMPEV_OFS_ENAB   = 8'h10;
    localparam logic [7:0] CMPEV_OFS_IRQCTL = 8'h14;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int CMPEV_CTL_ON      = 7;
    localparam int CMPEV_CTL_PIN     = 6;
    localparam int CMPEV_CTL_INV     = 5;
    localparam int CMPEV_CTL_EVS_HI  = 4;
    localparam int CMPEV_CTL_EVS_LO  = 3;
    localparam logic [7:0] CMPEV_CTL_RESET = 8'h1f;

    // ------------------------------------------------------------------
    // Status, flag, enable and interrupt control fields
    // ------------------------------------------------------------------
    localparam int CMPEV_STAT_C1 = 6;
    localparam int CMPEV_STAT_C2 = 7;
    localparam int CMPEV_FLAG_C1 = 4;
    localparam int CMPEV_FLAG_C2 = 5;
    localparam int CMPEV_IRQ_GLOBAL = 7;
    localparam int CMPEV_IRQ_PERIPH = 6;
    localparam logic [7:0] CMPEV_REG8_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Event select encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CMPEV_EVS_NONE = 2'h0,
        CMPEV_EVS_RISE = 2'h1,
        CMPEV_EVS_FALL = 2'h2,
        CMPEV_EVS_ANY  = 2'h3
    } cmpev_evs_t;

endpackage

// file: core/cmpev_chan_if.sv
// Signals between the register logic and one comparator channel.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface cmpev_chan_if;
    logic       comparator_on;
    logic       result_invert;
    logic [1:0] event_select;
    logic       raw;
    logic       result;
    logic       event_pulse;

    modport regs (output comparator_on, output result_invert, output event_select, output raw,
                  input result, input event_pulse);
    modport chan (input comparator_on, input result_invert, input event_select, input raw,
                  output result, output event_pulse);
endinterface

// file: core/cmpev_chan.sv
// One comparator channel: synchroniser, polarity and event detector.
// Assumes the raw result is asynchronous to clk_i.
`timescale 1ns/1ps

module cmpev_chan (
    // Clock and reset
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    // Channel signals
    cmpev_chan_if.chan  ch
);
    import cmpev_pkg::*;

    logic       sync1_q;
    logic       sync2_q;
    logic       result_q;
    logic       event_q;
    logic [1:0] evs_prev_q;
    logic       res_d;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= ch.raw;
            sync2_q <= sync1_q;
        end
    end

    // polarity after synchronisation; a disabled comparator reads as the invert bit
    always_comb begin
        res_d = (sync2_q & ch.comparator_on) ^ ch.result_invert;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_q   <= 1'b0;
            evs_prev_q <= CMPEV_CTL_RESET[CMPEV_CTL_EVS_HI:CMPEV_CTL_EVS_LO];
            event_q    <= 1'b0;
        end else begin
            result_q   <= res_d;
            evs_prev_q <= ch.event_select;
            case (ch.event_select)
                CMPEV_EVS_RISE: event_q <= res_d & ~result_q;
                CMPEV_EVS_FALL: event_q <= ~res_d & result_q;
                CMPEV_EVS_ANY:  event_q <= (res_d ^ result_q) | (evs_prev_q != CMPEV_EVS_ANY);
                default:        event_q <= 1'b0;
            endcase
        end
    end

    assign ch.result      = result_q;
    assign ch.event_pulse = event_q;
endmodule

// file: core/cmpev_top.sv
// Top of the comparator event logic: Wishbone registers, pin mux, flags.
// Assumes raw comparator results from the analog cores and port E
// data and direction from the port logic.
`timescale 1ns/1ps

module cmpev_top (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Analog comparator cores
    input  wire logic [1:0]  comparator_raw_i,
    output logic      [1:0]  comparator_on_o,
    // Port E pins 1 and 2
    input  wire logic [2:1]  port_e_data_i,
    input  wire logic [2:1]  port_e_direction_i,
    output logic      [2:1]  port_e_pin_o,
    output logic      [2:1]  port_e_pin_oe_o,
    // Interrupt and wake
    output logic             irq_o,
    output logic             wake_o
);
    import cmpev_pkg::*;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] ctl_q [2];
    logic [7:0] flags_q;
    logic [7:0] enab_q;
    logic [7:0] irqctl_q;
    logic [7:0] status;
    logic [1:0] evt;
    logic [1:0] res;
    logic [7:0] rdata;
    logic       req;
    logic       wr_en;

    cmpev_chan_if ch_if [2] ();

    // ------------------------------------------------------------------
    // Comparator channels
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_chan
            assign ch_if[g].comparator_on = ctl_q[g][CMPEV_CTL_ON];
            assign ch_if[g].result_invert = ctl_q[g][CMPEV_CTL_INV];
            assign ch_if[g].event_select  = ctl_q[g][CMPEV_CTL_EVS_HI:CMPEV_CTL_EVS_LO];
            assign ch_if[g].raw           = comparator_raw_i[g];
            assign res[g]                 = ch_if[g].result;
            assign evt[g]                 = ch_if[g].event_pulse;

            cmpev_chan u_chan (
                .clk_i (clk_i),
                .rst_i (rst_i),
                .ch    (ch_if[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // Accesses are taken on the first request cycle; ack follows one edge later
    assign req   = cyc_i & stb_i & ~ack_o;
    assign wr_en = req & we_i & sel_i[0];

    always_comb begin
        status                = 8'h00;
        status[CMPEV_STAT_C1] = res[0];
        status[CMPEV_STAT_C2] = res[1];
    end

    always_comb begin
        if (adr_i == CMPEV_OFS_CTL1) begin
            rdata = ctl_q[0];
        end else if (adr_i == CMPEV_OFS_CTL2) begin
            rdata = ctl_q[1];
        end else if (adr_i == CMPEV_OFS_STATUS) begin
            rdata = status;
        end else if (adr_i == CMPEV_OFS_FLAGS) begin
            rdata = flags_q;
        end else if (adr_i == CMPEV_OFS_ENAB) begin
            rdata = enab_q;
        end else if (adr_i == CMPEV_OFS_IRQCTL) begin
            rdata = irqctl_q;
        end else begin
            rdata = 8'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= req;
            if (req && !we_i) begin
                dat_o <= {24'h00_0000, rdata};
            end
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    // reset loads defaults, comparators off
    // only reset or a bus write changes them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_q[0] <= CMPEV_CTL_RESET;
            ctl_q[1] <= CMPEV_CTL_RESET;
        end else if (wr_en && adr_i == CMPEV_OFS_CTL1) begin
            ctl_q[0] <= dat_i[7:0];
        end else if (wr_en && adr_i == CMPEV_OFS_CTL2) begin
            ctl_q[1] <= dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enab_q   <= CMPEV_REG8_RESET;
            irqctl_q <= CMPEV_REG8_RESET;
        end else begin
            if (wr_en && adr_i == CMPEV_OFS_ENAB) begin
                enab_q <= dat_i[7:0];
            end
            if (wr_en && adr_i == CMPEV_OFS_IRQCTL) begin
                irqctl_q <= dat_i[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Event flags
    // ------------------------------------------------------------------
    // flags at bits 5:4; other bits plain storage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_q <= CMPEV_REG8_RESET;
        end else begin
            // software write stores zero or one
            if (wr_en && adr_i == CMPEV_OFS_FLAGS) begin
                flags_q <= dat_i[7:0];
            end
            // flags set whatever the enables; set beats clear
            if (evt[0]) begin
                flags_q[CMPEV_FLAG_C1] <= 1'b1;
            end
            if (evt[1]) begin
                flags_q[CMPEV_FLAG_C2] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt and wake
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o  <= 1'b0;
            wake_o <= 1'b0;
        end else begin
            irq_o  <= (|(flags_q[CMPEV_FLAG_C2:CMPEV_FLAG_C1] & enab_q[CMPEV_FLAG_C2:CMPEV_FLAG_C1]))
                      & irqctl_q[CMPEV_IRQ_PERIPH] & irqctl_q[CMPEV_IRQ_GLOBAL];
            // wake needs only the per-comparator enable
            wake_o <= |(flags_q[CMPEV_FLAG_C2:CMPEV_FLAG_C1] & enab_q[CMPEV_FLAG_C2:CMPEV_FLAG_C1]);
        end
    end

    // ------------------------------------------------------------------
    // Pins and analog enables
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_e_pin_o    <= 2'h0;
            port_e_pin_oe_o <= 2'h0;
            comparator_on_o <= 2'h0;
        end else begin
            port_e_pin_o[1] <= ctl_q[0][CMPEV_CTL_PIN] ? res[0] : port_e_data_i[1];
            port_e_pin_o[2] <= ctl_q[1][CMPEV_CTL_PIN] ? res[1] : port_e_data_i[2];
            port_e_pin_oe_o <= ~port_e_direction_i;
            comparator_on_o <= {ctl_q[1][CMPEV_CTL_ON], ctl_q[0][CMPEV_CTL_ON]};
        end
    end
endmodule

// file: verification/cmpev_sva.sv
// Port checker for the comparator event logic.
// Assumes it is bound onto cmpev_top.
`timescale 1ns/1ps

module cmpev_sva
    import cmpev_pkg::*;
(
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Wishbone
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // Comparators, pins, interrupt
    input wire logic [1:0]  comparator_raw_i,
    input wire logic [1:0]  comparator_on_o,
    input wire logic [2:1]  port_e_data_i,
    input wire logic [2:1]  port_e_direction_i,
    input wire logic [2:1]  port_e_pin_o,
    input wire logic [2:1]  port_e_pin_oe_o,
    input wire logic        irq_o,
    input wire logic        wake_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire req = cyc_i && stb_i && !ack_o;

    AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_ANSWER: assert property (req |=> ack_o)
        else $error("request not acknowledged");
    AST_ACK_CAUSE: assert property ($rose(ack_o) |-> $past(req))
        else $error("ack without request");
    AST_STAT_READ: assert property (
        req && !we_i && adr_i == CMPEV_OFS_STATUS |=> dat_o[5:0] == 6'h00 && dat_o[31:8] == 24'h0)
        else $error("status read has stray bits");
    AST_PIN_OE: assert property (
        !$past(rst_i) |-> port_e_pin_oe_o == ~$past(port_e_direction_i))
        else $error("pin enable not from direction");
    AST_RESET_OFF: assert property (
        $past(rst_i) |-> comparator_on_o == 2'b00 && !irq_o && !wake_o)
        else $error("outputs active after reset");
    AST_ON_WRITE: assert property (
        !$past(rst_i) && $changed(comparator_on_o) |-> $past(req && we_i, 2))
        else $error("enable changed without write");
    AST_IRQ_GATE: assert property (irq_o |-> wake_o)
        else $error("irq without enabled flag");
    AST_FLAG_HOLD: assert property (
        !$past(rst_i) && $fell(wake_o) |-> $past(cyc_i && stb_i && we_i, 2))
        else $error("flag dropped without write");

    cover property (req && we_i);
    cover property ($rose(irq_o));
    cover property ($rose(wake_o));
endmodule

// file: verification/cmpev_analog_model.sv
// Behavioural analog comparator pair.
// Assumes level_i is the wanted comparison result per core.
`timescale 1ns/1ps

module cmpev_analog_model (
    // Clock
    input wire logic       clk_i,
    // Control and stimulus
    input wire logic [1:0] on_i,
    input wire logic [1:0] level_i,
    // Raw results
    output logic     [1:0] raw_o
);
    always_ff @(posedge clk_i) begin
        raw_o <= level_i & on_i;
    end
endmodule

// file: verification/cmpev_tb.sv
// Self-checking bench for the comparator event logic.
// Assumes cmpev_top and the analog model; sel_i follows the bus request.
`timescale 1ns/1ps

module cmpev_tb;
    import cmpev_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic [3:0]  sel   = 4'h0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [1:0]  raw;
    logic [1:0]  on;
    logic [1:0]  lvl   = 2'b00;
    logic [2:1]  pd    = 2'b00;
    logic [2:1]  dir   = 2'b11;
    logic [2:1]  pin;
    logic [2:1]  oe;
    logic        irq;
    logic        wake;
    int          error_cnt = 0;
    int          n_checks  = 0;

    always #5 clk_i = ~clk_i;

    cmpev_analog_model ana_u (.clk_i(clk_i), .on_i(on), .level_i(lvl), .raw_o(raw));
    cmpev_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .comparator_raw_i(raw), .comparator_on_o(on), .port_e_data_i(pd), .port_e_direction_i(dir),
        .port_e_pin_o(pin), .port_e_pin_oe_o(oe), .irq_o(irq), .wake_o(wake));

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel   <= 4'h1;
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        r = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        sel   <= 4'h0;
        if (ack_o !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH t=%0t no ack from bus", $time);
            give_verdict();
        end
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        wb(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        wb(1'b0, a, 8'h00, r);
    endtask

    task automatic t_reset;
        logic [7:0] r;
        for (int i = 0; i < 6; i++) begin
            rd(8'(i * 4), r);
            chk(r, i < 2 ? CMPEV_CTL_RESET : CMPEV_REG8_RESET, "reset value");
        end
        rd(8'h20, r);
        chk(r, 8'h00, "unmapped");
        wr(CMPEV_OFS_STATUS, 8'hff);
        rd(CMPEV_OFS_STATUS, r);
        chk(r, 8'h00, "status write");
        $display("test reset done");
    endtask

    task automatic t_edges;
        logic [7:0] a, fb, sb, r, st;
        logic [2:0] m;
        for (int c = 0; c < 2; c++) begin
            for (int v = 0; v < 8; v++) begin
                m  = v[2:0];
                a  = c ? CMPEV_OFS_CTL2 : CMPEV_OFS_CTL1;
                fb = 8'h10 << c;
                sb = 8'h40 << c;
                wr(CMPEV_OFS_FLAGS, 8'h00);
                wr(a, {2'b10, m, 3'b000});
                repeat (6) @(posedge clk_i);
                rd(CMPEV_OFS_FLAGS, r);
                chk(r & fb, m[1:0] == 2'b11 ? fb : 8'h00, "select");
                wr(CMPEV_OFS_FLAGS, 8'h00);
                rd(CMPEV_OFS_STATUS, st);
                chk(st & sb, m[2] ? sb : 8'h00, "status copy");
                lvl[c] <= 1'b1;
                repeat (8) @(posedge clk_i);
                rd(CMPEV_OFS_STATUS, r);
                chk(r & sb, m[2] ? 8'h00 : sb, "status");
                if (m[1:0] == 2'b11) chk((r ^ st) & sb, sb, "change seen");
                rd(CMPEV_OFS_FLAGS, r);
                chk(r & fb, (m[1:0] == 3 || m[1:0] == {m[2], !m[2]}) ? fb : 8'h00, "rise");
                wr(CMPEV_OFS_FLAGS, 8'h00);
                lvl[c] <= 1'b0;
                repeat (8) @(posedge clk_i);
                rd(CMPEV_OFS_FLAGS, r);
                chk(r & fb, (m[1:0] == 3 || m[1:0] == {!m[2], m[2]}) ? fb : 8'h00, "fall");
            end
        end
        $display("test edges done");
    endtask

    task automatic t_irq;
        logic [7:0] r;
        wr(CMPEV_OFS_CTL1, 8'h80);
        wr(CMPEV_OFS_FLAGS, 8'h00);
        wr(CMPEV_OFS_ENAB, 8'h20);
        wr(CMPEV_OFS_FLAGS, 8'h10);
        chk({wake, irq}, 8'h00, "wrong enable bit");
        wr(CMPEV_OFS_ENAB, 8'h10);
        repeat (3) @(posedge clk_i);
        chk({wake, irq}, 8'h02, "wake only");
        wr(CMPEV_OFS_IRQCTL, 8'h40);
        chk({wake, irq}, 8'h02, "periph only");
        wr(CMPEV_OFS_IRQCTL, 8'hc0);
        chk({wake, irq}, 8'h03, "irq");
        repeat (20) @(posedge clk_i);
        rd(CMPEV_OFS_FLAGS, r);
        chk(r, 8'h10, "flag held");
        rd(CMPEV_OFS_CTL1, r);
        chk(r, 8'h80, "ctl kept");
        wr(CMPEV_OFS_FLAGS, 8'h00);
        repeat (2) @(posedge clk_i);
        chk({wake, irq}, 8'h00, "cleared");
        $display("test irq done");
    endtask

    task automatic t_pin;
        dir <= 2'b10;
        lvl <= 2'b01;
        pd  <= 2'b11;
        wr(CMPEV_OFS_CTL1, 8'hc0);
        wr(CMPEV_OFS_CTL2, 8'h80);
        repeat (8) @(posedge clk_i);
        chk({pin, oe, on}, 8'h37, "pin drive");
        wr(CMPEV_OFS_CTL1, 8'h00);
        repeat (2) @(posedge clk_i);
        chk({pin, oe, on}, 8'h36, "port data");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        $display("test pin done");
    endtask

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_edges();
        t_irq();
        t_pin();
        t_reset();
        give_verdict();
    end
endmodule

bind cmpev_top cmpev_sva chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .comparator_raw_i(comparator_raw_i), .comparator_on_o(comparator_on_o), .port_e_data_i(port_e_data_i),
    .port_e_direction_i(port_e_direction_i), .port_e_pin_o(port_e_pin_o), .port_e_pin_oe_o(port_e_pin_oe_o),
    .irq_o(irq_o), .wake_o(wake_o));
